// *** hdl/asf_pkg.sv ***
// Constants, types and field layout of the converter status word.
// Assumes a single clock domain and a serial framing block that decodes
// the no-op and register-read commands for this block.
// Notes on behaviour
// - Status word is 16 bits, read only, address 01h, reset value 0540h.
// - Bit 15 reads 1 while the serial interface is locked.
// - The unlock command returns the lock indicator to 0.
// - Bit 14 sets on each converter resync and stays until a status read.
// - Bit 13 sets when the periodic configuration checksum detects a fault.
// - Bit 12 sets on a checksum error in a received serial frame.
// - Sticky fault flags clear on a status read by no-op or register read.
// - Bit 11 shows checksum type, 0 CCITT, 1 ANSI; zero after reset.
// - Bit 10 sets on pin reset, power-on reset or reset command; resets 1.
// - Reset-occurred bit clears only by writing 0 to the mode reset bit.
// - Bits 9:8 show word length; reset value 01 meaning 24 bits.
// - Bit 7 sets on a parity fault in the trim memory.
// - A persisting trim parity fault sets the flag again after a clear.
// - Bit 6 sets on isolated supply or barrier fault; reset value 1.
// - Bits 2 to 0 show new data for channels 2 to 0.
// - Checksum type and word length mirror mode bit 11 and bits 9:8.

package asf_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h01;
	localparam logic [7:0] ADDR_OPERATING_MODE = 8'h02;
	localparam logic [15:0] RST_DEVICE_STATUS = 16'h0540;
	localparam logic [15:0] RST_OPERATING_MODE = 16'h0510;

	// ==========================================================
	// Status word field positions
	localparam int ST_LOCK = 15;
	localparam int ST_RESYNC = 14;
	localparam int ST_CFG_CRC = 13;
	localparam int ST_RX_CRC = 12;
	localparam int ST_CRC_TYPE = 11;
	localparam int ST_RESET = 10;
	localparam int ST_WLEN_LO = 8;
	localparam int ST_TRIM = 7;
	localparam int ST_SUPPLY = 6;
	localparam int ST_NEW_LO = 0;

	// ==========================================================
	// Mode register field positions used here
	localparam int MD_CRC_TYPE = 11;
	localparam int MD_RESET = 10;
	localparam int MD_WLEN_LO = 8;

	// ==========================================================
	// Reset values of the individual fields
	localparam logic RST_RESET_FLAG = 1'b1;
	localparam logic RST_SUPPLY_FLAG = 1'b1;
	localparam logic [1:0] RST_WLEN = 2'h1;
	localparam int NUM_CH = 3;

	typedef struct packed {
		logic lock;
		logic reset_flag;
		logic [15:0] rdata;
	} asf_state_t;

endpackage

// *** hdl/asf_sticky.sv ***
// One sticky event flag: set wins over clear.
// Assumes events and clears are single-clock synchronous pulses or levels.
`timescale 1ns/1ns

module asf_sticky #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Control
	input wire logic set_i,
	input wire logic clr_i,
	// State
	output logic flag_o
);

	logic flag_ff;
	logic nxt_flag;

	always_comb begin
		nxt_flag = flag_ff;
		if (clr_i) begin
			nxt_flag = 1'b0;
		end
		if (set_i) begin
			nxt_flag = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flag_ff <= RST_VAL;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	assign flag_o = flag_ff;

endmodule

// *** hdl/asf_mode_mirror.sv ***
// Mirror of the mode register fields shown in the status word.
// Assumes mode writes arrive as one-cycle strobes with a 16-bit value.
`timescale 1ns/1ns

module asf_mode_mirror (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Mode register write
	input wire logic mode_wr_i,
	input wire logic [15:0] mode_wdata_i,
	// Mirrored fields
	output logic crc_type_o,
	output logic [1:0] word_size_o,
	output logic ack_reset_o
);

	typedef struct packed {
		logic crc_type;
		logic [1:0] wsize;
	} asf_mirror_t;

	asf_mirror_t st_ff;
	asf_mirror_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (mode_wr_i) begin
			nxt_st.crc_type = mode_wdata_i[asf_pkg::MD_CRC_TYPE];
			nxt_st.wsize = mode_wdata_i[asf_pkg::MD_WLEN_LO +: 2];
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_ff.crc_type <= 1'b0;
			st_ff.wsize <= asf_pkg::RST_WLEN;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign crc_type_o = st_ff.crc_type;
	assign word_size_o = st_ff.wsize;
	// Writing 0 to the mode reset bit acknowledges a reset
	assign ack_reset_o = mode_wr_i && !mode_wdata_i[asf_pkg::MD_RESET];

endmodule

// *** hdl/asf_status_reg.sv ***
// Converter status word register bank.
// Assumes the serial block decodes commands into one-cycle strobes and
// that fault sources deliver synchronous pulses or levels on mclk_i.
`timescale 1ns/1ns

module asf_status_reg (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Command strobes from the serial block
	input wire logic lock_cmd_i,
	input wire logic unlock_cmd_i,
	input wire logic reset_cmd_i,
	input wire logic noop_cmd_i,
	input wire logic read_register_command_i,
	input wire logic [7:0] reg_addr_i,
	// Mode register write
	input wire logic mode_wr_i,
	input wire logic [15:0] mode_wdata_i,
	// Event sources
	input wire logic resync_event_flag_i,
	input wire logic cfg_crc_fault_i,
	input wire logic rx_crc_fault_i,
	input wire logic trim_parity_fault_i,
	input wire logic isolated_supply_fault_i,
	input wire logic [2:0] new_sample_i,
	// Status word
	output logic [15:0] status_o,
	output logic [15:0] rdata_o,
	output logic sample_word_size_crc_o
);

	asf_pkg::asf_state_t st_ff;
	asf_pkg::asf_state_t nxt_st;

	logic status_rd;
	logic crc_type;
	logic [1:0] sample_word_size;
	logic ack_reset;
	logic [15:0] word;
	logic [asf_pkg::NUM_CH-1:0] ch_new_sample;
	logic [4:0] flag_set;
	logic [4:0] flag_q;

	// ==========================================================
	// Status read detection
	always_comb begin
		status_rd = noop_cmd_i;
		if (read_register_command_i &&
				reg_addr_i == asf_pkg::ADDR_DEVICE_STATUS) begin
			status_rd = 1'b1;
		end
	end

	// ==========================================================
	// Mode register mirror
	asf_mode_mirror u_mirror (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.mode_wr_i(mode_wr_i),
		.mode_wdata_i(mode_wdata_i),
		.crc_type_o(crc_type),
		.word_size_o(sample_word_size),
		.ack_reset_o(ack_reset)
	);

	// ==========================================================
	// Sticky fault flags
	assign flag_set[0] = resync_event_flag_i;
	assign flag_set[1] = cfg_crc_fault_i;
	assign flag_set[2] = rx_crc_fault_i;
	assign flag_set[3] = trim_parity_fault_i;
	assign flag_set[4] = isolated_supply_fault_i;

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_flag
			asf_sticky #(
				.RST_VAL((gi == 4) ? asf_pkg::RST_SUPPLY_FLAG : 1'b0)
			) u_flag (
				.mclk_i(mclk_i),
				.reset_n_i(reset_n_i),
				.set_i(flag_set[gi]),
				.clr_i(status_rd),
				.flag_o(flag_q[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Channel new-data indicators
	generate
		for (gi = 0; gi < asf_pkg::NUM_CH; gi++) begin : g_ch
			assign ch_new_sample[gi] = new_sample_i[gi];
		end
	endgenerate

	// ==========================================================
	// Lock and reset-occurred state, read data
	always_comb begin
		nxt_st = st_ff;
		if (lock_cmd_i) begin
			nxt_st.lock = 1'b1;
		end
		if (unlock_cmd_i) begin
			nxt_st.lock = 1'b0;
		end
		if (ack_reset) begin
			nxt_st.reset_flag = 1'b0;
		end
		if (reset_cmd_i) begin
			nxt_st.reset_flag = 1'b1;
		end
		if (status_rd) begin
			nxt_st.rdata = word;
		end
	end

	always_comb begin
		word = 16'h0000;
		word[asf_pkg::ST_LOCK] = st_ff.lock;
		word[asf_pkg::ST_RESYNC] = flag_q[0];
		word[asf_pkg::ST_CFG_CRC] = flag_q[1];
		word[asf_pkg::ST_RX_CRC] = flag_q[2];
		word[asf_pkg::ST_CRC_TYPE] = crc_type;
		word[asf_pkg::ST_RESET] = st_ff.reset_flag;
		word[asf_pkg::ST_WLEN_LO +: 2] = sample_word_size;
		word[asf_pkg::ST_TRIM] = flag_q[3];
		word[asf_pkg::ST_SUPPLY] = flag_q[4];
		word[asf_pkg::ST_NEW_LO +: asf_pkg::NUM_CH] = ch_new_sample;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_ff.lock <= 1'b0;
			st_ff.reset_flag <= asf_pkg::RST_RESET_FLAG;
			st_ff.rdata <= asf_pkg::RST_DEVICE_STATUS;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign status_o = word;
	assign rdata_o = st_ff.rdata;
	assign sample_word_size_crc_o = crc_type;

endmodule

// *** sim/asf_status_reg_sva.sv ***
// Assertions on the status word register bank ports.
// Bound into asf_status_reg; one clock domain, async active-low reset.
`timescale 1ns/1ns

module asf_status_reg_chk (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Commands
	input wire logic lock_cmd_i,
	input wire logic unlock_cmd_i,
	input wire logic reset_cmd_i,
	input wire logic noop_cmd_i,
	input wire logic read_register_command_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic mode_wr_i,
	input wire logic [15:0] mode_wdata_i,
	// Events
	input wire logic resync_event_flag_i,
	input wire logic cfg_crc_fault_i,
	input wire logic rx_crc_fault_i,
	input wire logic trim_parity_fault_i,
	input wire logic isolated_supply_fault_i,
	input wire logic [2:0] new_sample_i,
	// Outputs
	input wire logic [15:0] status_o,
	input wire logic [15:0] rdata_o
);
	wire rd = noop_cmd_i | read_register_command_i & reg_addr_i == 8'h01;
	wire ev = resync_event_flag_i | cfg_crc_fault_i | rx_crc_fault_i
		| trim_parity_fault_i | isolated_supply_fault_i;
	wire [3:0] fv = {cfg_crc_fault_i, rx_crc_fault_i, trim_parity_fault_i,
		isolated_supply_fault_i};
	wire [2:0] mf = {mode_wdata_i[11], mode_wdata_i[9:8]};
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	// Bit 10 is the reset flag, not a mirror, so it is left out
	property p_mirror;
		mode_wr_i |=> {status_o[11], status_o[9:8]} == $past(mf);
	endproperty
	// ==========================================================
	// Assertions
	a_lock_set: assert property (
		lock_cmd_i && !unlock_cmd_i |=> status_o[15])
		else $error("lock bit not set");
	a_unlock_clr: assert property (unlock_cmd_i |=> !status_o[15])
		else $error("lock bit not cleared");
	a_resync_set: assert property (
		resync_event_flag_i |=> status_o[14])
		else $error("resync flag lost");
	a_fault_set: assert property (
		1'b1 |=> ({status_o[13:12], status_o[7:6]} & $past(fv)) == $past(fv))
		else $error("fault flag lost");
	a_read_clear: assert property (
		rd && !ev |=> status_o[14:12] == 3'h0 && status_o[7:6] == 2'h0)
		else $error("flags not cleared");
	a_low_bits: assert property (
		status_o[5:0] == {3'h0, new_sample_i})
		else $error("low bits wrong");
	a_reset_cmd: assert property (reset_cmd_i |=> status_o[10])
		else $error("reset flag not set");
	a_reset_val: assert property (
		$rose(reset_n_i) |-> rdata_o == 16'h0540
		&& {status_o[15:3], 3'h0} == 16'h0540)
		else $error("reset value wrong");
	a_reset_ack: assert property (
		mode_wr_i && !mode_wdata_i[10] && !reset_cmd_i |=> !status_o[10])
		else $error("reset flag kept");
	a_mode_copy: assert property (p_mirror)
		else $error("mode mirror wrong");
	a_read_snap: assert property (rd |=> rdata_o == $past(status_o))
		else $error("snapshot wrong");
	c_read_event: cover property (rd && resync_event_flag_i);
	c_ack: cover property (mode_wr_i && !mode_wdata_i[10]);
	c_lock: cover property (lock_cmd_i);
	c_trim_hold: cover property (rd && trim_parity_fault_i);
endmodule

bind asf_status_reg asf_status_reg_chk chk (.*);

// *** sim/asf_host_model.sv ***
// Host controller model: issues decoded serial commands as strobes.
// Drives just after rising edges; the bench calls send.
`timescale 1ns/1ns

module asf_host_model (
	// Clock
	input wire logic mclk_i,
	// Strobes: lock, unlock, reset, noop, read, mode write
	output logic [5:0] strb_o,
	output logic [7:0] addr_o,
	output logic [15:0] wdata_o
);
	initial begin
		strb_o = 6'h00;
		addr_o = 8'h00;
		wdata_o = 16'h0000;
	end
	// Hold one edge, then release with inverted data on the bus
	task automatic send(input logic [5:0] m, input logic [15:0] d);
		@(posedge mclk_i);
		strb_o <= m;
		addr_o <= d[7:0];
		wdata_o <= d;
		@(posedge mclk_i);
		strb_o <= 6'h00;
		addr_o <= ~d[7:0];
		wdata_o <= ~d;
	endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the status word register bank.
// Host model drives commands; the bench drives events and new data.
`timescale 1ns/1ns

module tb;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [4:0] ev = 5'h00;
	logic [2:0] ns = 3'h0;
	logic [5:0] hs;
	logic [7:0] ha;
	logic [15:0] hw, st, rdo, exp_rd;
	logic crc, lk, rf, ct;
	logic [1:0] wl;
	logic [4:0] fl;
	int err_total = 0;
	int tests_run = 0;
	wire rd = hs[3] | hs[4] & ha == 8'h01;
	// Expected status word from the modelled fields
	function automatic logic [15:0] pack_status(input logic l, r, c,
		input logic [1:0] w, input logic [4:0] f, input logic [2:0] n);
		return {l, f[4:2], c, r, w, f[1:0], 3'h0, n};
	endfunction
	wire [15:0] exp_st = pack_status(lk, rf, ct, wl, fl, ns);
	always #4 mclk_i = ~mclk_i;
	asf_host_model host (
		.mclk_i(mclk_i),
		.strb_o(hs),
		.addr_o(ha),
		.wdata_o(hw)
	);
	asf_status_reg dut (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.lock_cmd_i(hs[0]),
		.unlock_cmd_i(hs[1]),
		.reset_cmd_i(hs[2]),
		.noop_cmd_i(hs[3]),
		.read_register_command_i(hs[4]),
		.reg_addr_i(ha),
		.mode_wr_i(hs[5]),
		.mode_wdata_i(hw),
		.resync_event_flag_i(ev[4]),
		.cfg_crc_fault_i(ev[3]),
		.rx_crc_fault_i(ev[2]),
		.trim_parity_fault_i(ev[1]),
		.isolated_supply_fault_i(ev[0]),
		.new_sample_i(ns),
		.status_o(st),
		.rdata_o(rdo),
		.sample_word_size_crc_o(crc)
	);
	// ==========================================================
	// Reference model
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{lk, rf, ct, wl, fl, exp_rd} <= {5'h09, 5'h01, 16'h0540};
		end else begin
			lk <= (lk | hs[0]) & ~hs[1];
			rf <= hs[2] | rf & ~(hs[5] & ~hw[10]);
			fl <= (rd ? 5'h00 : fl) | ev;
			if (hs[5]) begin
				{ct, wl} <= {hw[11], hw[9:8]};
			end
			if (rd) begin
				exp_rd <= exp_st;
			end
		end
	end
	task automatic chk(input string n, input logic [15:0] s, e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	always @(negedge mclk_i) begin
		chk("status", st, exp_st);
		chk("rdata", rdo, exp_rd);
		chk("crc", {15'h0, crc}, {15'h0, ct});
	end
	task automatic pulse(input logic [5:0] m, input logic [15:0] d,
		input logic [4:0] e);
		fork
			host.send(m, d);
			begin
				@(posedge mclk_i);
				ev <= e;
				ns <= 3'($urandom);
				@(posedge mclk_i);
				ev <= 5'h00;
			end
		join
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		wrap_up();
	end
	initial begin
		void'($urandom(17980));
		repeat (20) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		$display("reset values done");
		for (int i = 0; i < 8; i++) begin
			pulse(6'h20, 16'(i * 9) << 8, 5'h00);
		end
		$display("mode mirror done");
		pulse(6'h08, 16'h0000, 5'h10);
		pulse(6'h10, 16'h0002, 5'h0e);
		pulse(6'h10, 16'h0001, 5'h02);
		pulse(6'h08, 16'h0000, 5'h02);
		pulse(6'h01, 16'h0000, 5'h01);
		pulse(6'h03, 16'h0000, 5'h00);
		pulse(6'h24, 16'h0000, 5'h00);
		$display("corner cases done");
		reset_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (300) pulse(6'($urandom), 16'($urandom) & 16'hff03,
			5'($urandom & $urandom));
		$display("random traffic done");
		wrap_up();
	end
endmodule
